//--- logic/byte_add_sub.sv
`timescale 1ns/10ps
// Byte adder and subtractor with carry in and flag outputs
module byte_add_sub (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  wire logic       subtract,
	output logic [7:0]      r,
	output logic            c,
	output logic            h,
	output logic            v,
	output logic            z
);

	logic [8:0] full;
	logic [4:0] nib;

	// Borrow for subtraction shows as the ninth bit
	assign full = subtract ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
	                       : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
	assign nib  = subtract ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
	                       : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
	assign r    = full[7:0];
	assign c    = full[8];
	assign h    = nib[4];

	// Signed overflow differs for add and subtract
	assign v = subtract ? ((a[7] != b[7]) && (r[7] != a[7]))
	                    : ((a[7] == b[7]) && (r[7] != a[7]));
	assign z = (r == 8'h00);

endmodule

//--- logic/exec_pkg.sv
package exec_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W   = 8;
	localparam int PC_W     = 16;
	localparam int OFFSET_W = 7;
	localparam int BITSEL_W = 3;
	localparam int CNT_W    = 2;

	// ----------------------------------------
	// Status register bit positions
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ----------------------------------------
	// Clock counts per operation
	// ----------------------------------------
	localparam logic [1:0] CYC_ALU        = 2'h1;
	localparam logic [1:0] CYC_WORD       = 2'h2;
	localparam logic [1:0] CYC_JUMP       = 2'h2;
	localparam logic [1:0] CYC_CALL       = 2'h3;
	localparam logic [1:0] CYC_NO_SKIP    = 2'h1;
	localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
	localparam logic [1:0] CYC_SKIP_LONG  = 2'h3;
	localparam logic [1:0] CYC_BR_NOT     = 2'h1;
	localparam logic [1:0] CYC_BR_TAKEN   = 2'h2;

	// ----------------------------------------
	// Program counter steps
	// ----------------------------------------
	localparam logic [15:0] PC_STEP       = 16'h0001;
	localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
	localparam logic [15:0] PC_SKIP_LONG  = 16'h0003;

	// ----------------------------------------
	// Operations
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_ADD, OP_ADD_CARRY, OP_ADD_IMM_WORD,
		OP_SUB, OP_SUB_CONST, OP_SUB_BORROW, OP_SUB_CONST_BORROW, OP_SUB_IMM_WORD,
		OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR,
		OP_SET_BITS, OP_CLEAR_BITS, OP_TEST,
		OP_JUMP_PTR, OP_CALL_PTR, OP_CMP_SKIP_EQ,
		OP_CMP, OP_CMP_BORROW, OP_CMP_IMM,
		OP_SKIP_REG_CLEAR, OP_SKIP_REG_SET, OP_SKIP_IO_CLEAR, OP_SKIP_IO_SET,
		OP_BR_FLAG_SET, OP_BR_FLAG_CLEAR
	} op_t;

	// Decoded instruction with its operands
	typedef struct packed {
		op_t                 op;
		logic [DATA_W-1:0]   dst;
		logic [DATA_W-1:0]   src;
		logic [PC_W-1:0]     word;
		logic [PC_W-1:0]     ptr;
		logic [DATA_W-1:0]   io_val;
		logic [BITSEL_W-1:0] bit_sel;
		logic [OFFSET_W-1:0] offset;
		logic [PC_W-1:0]     pc;
		logic                next_two_word;
	} exec_req_t;

	// Outcome handed back to the core
	typedef struct packed {
		logic              dst_we;
		logic [DATA_W-1:0] dst_data;
		logic              word_we;
		logic [PC_W-1:0]   word_data;
		logic [PC_W-1:0]   pc_next;
		logic              push_en;
		logic [PC_W-1:0]   push_addr;
	} exec_res_t;

endpackage

//--- logic/exec_unit.sv
`timescale 1ns/10ps
module exec_unit (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                start,
	input  wire exec_pkg::exec_req_t req,
	output logic                     ready,
	output logic                     done,
	output exec_pkg::exec_res_t      res,
	output logic [7:0]               status_register
);

	typedef enum logic {ST_IDLE, ST_BUSY} state_t;

	state_t                   state_reg;
	logic [exec_pkg::CNT_W-1:0] cnt_reg;
	logic                     done_reg;
	exec_pkg::exec_res_t      res_reg;
	exec_pkg::exec_res_t      pend_reg;
	exec_pkg::exec_res_t      res_fin;
	logic [7:0]               status_register_reg;
	logic [7:0]               status_register_pend_reg;
	logic [7:0]               status_register_take;
	logic [7:0]               status_register_word;
	logic                     word_op_reg;
	logic                     word_sub_reg;
	logic [7:0]               word_hi_reg;
	logic                     carry_reg;
	logic [7:0]               lo_res_reg;
	logic                     lo_zero_reg;
	logic [1:0]               cyc_take;
	exec_pkg::exec_res_t      res_take;

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	wire exec_pkg::op_t op = req.op;
	wire is_word   = op inside {exec_pkg::OP_ADD_IMM_WORD, exec_pkg::OP_SUB_IMM_WORD};
	wire is_sub    = op inside {exec_pkg::OP_SUB, exec_pkg::OP_SUB_CONST, exec_pkg::OP_SUB_BORROW,
	                            exec_pkg::OP_SUB_CONST_BORROW, exec_pkg::OP_SUB_IMM_WORD,
	                            exec_pkg::OP_CMP, exec_pkg::OP_CMP_BORROW, exec_pkg::OP_CMP_IMM};
	wire use_carry = op inside {exec_pkg::OP_ADD_CARRY, exec_pkg::OP_SUB_BORROW,
	                            exec_pkg::OP_SUB_CONST_BORROW, exec_pkg::OP_CMP_BORROW};
	wire is_cmp    = op inside {exec_pkg::OP_CMP, exec_pkg::OP_CMP_BORROW, exec_pkg::OP_CMP_IMM};
	wire is_arith  = op inside {exec_pkg::OP_ADD, exec_pkg::OP_ADD_CARRY, exec_pkg::OP_SUB,
	                            exec_pkg::OP_SUB_CONST, exec_pkg::OP_SUB_BORROW,
	                            exec_pkg::OP_SUB_CONST_BORROW} || is_cmp;
	wire is_logic  = op inside {exec_pkg::OP_AND, exec_pkg::OP_AND_CONST, exec_pkg::OP_OR,
	                            exec_pkg::OP_OR_CONST, exec_pkg::OP_XOR, exec_pkg::OP_SET_BITS,
	                            exec_pkg::OP_CLEAR_BITS, exec_pkg::OP_TEST};
	wire is_skip   = op inside {exec_pkg::OP_CMP_SKIP_EQ, exec_pkg::OP_SKIP_REG_CLEAR,
	                            exec_pkg::OP_SKIP_REG_SET, exec_pkg::OP_SKIP_IO_CLEAR,
	                            exec_pkg::OP_SKIP_IO_SET};
	wire is_branch = op inside {exec_pkg::OP_BR_FLAG_SET, exec_pkg::OP_BR_FLAG_CLEAR};

	// ----------------------------------------
	// Bitwise results
	// ----------------------------------------
	wire [7:0] logic_res =
		(op inside {exec_pkg::OP_AND, exec_pkg::OP_AND_CONST}) ? (req.dst & req.src) :
		(op inside {exec_pkg::OP_OR, exec_pkg::OP_OR_CONST})   ? (req.dst | req.src) :
		(op == exec_pkg::OP_XOR)                               ? (req.dst ^ req.src) :
		(op == exec_pkg::OP_SET_BITS)                          ? (req.dst | req.src) :
		(op == exec_pkg::OP_CLEAR_BITS)                        ? (req.dst & ~req.src) :
		                                                         (req.dst & req.dst);

	// ----------------------------------------
	// Shared adder, low byte at take, high byte later
	// ----------------------------------------
	wire       hi_phase = (state_reg == ST_BUSY);
	wire [7:0] add_a    = hi_phase ? word_hi_reg : (is_word ? req.word[7:0] : req.dst);
	wire [7:0] add_b    = hi_phase ? 8'h00 : req.src;
	wire       add_cin  = hi_phase ? carry_reg : (use_carry & status_register_reg[exec_pkg::FLAG_C]);
	wire       add_sub  = hi_phase ? word_sub_reg : is_sub;
	wire [7:0] add_r;
	wire       add_c;
	wire       add_h;
	wire       add_v;
	wire       add_z;

	byte_add_sub u_add (
		.a        (add_a),
		.b        (add_b),
		.cin      (add_cin),
		.subtract (add_sub),
		.r        (add_r),
		.c        (add_c),
		.h        (add_h),
		.v        (add_v),
		.z        (add_z)
	);

	// ----------------------------------------
	// Skip and branch conditions
	// ----------------------------------------
	wire reg_bit = req.dst[req.bit_sel];
	wire io_bit  = req.io_val[req.bit_sel];
	wire skip_cond =
		(op == exec_pkg::OP_CMP_SKIP_EQ)    ? (req.dst == req.src) :
		(op == exec_pkg::OP_SKIP_REG_CLEAR) ? !reg_bit :
		(op == exec_pkg::OP_SKIP_REG_SET)   ? reg_bit :
		(op == exec_pkg::OP_SKIP_IO_CLEAR)  ? !io_bit :
		                                      io_bit;
	wire flag_bit = status_register_reg[req.bit_sel];
	wire br_taken = (op == exec_pkg::OP_BR_FLAG_SET) ? flag_bit : !flag_bit;

	// Offset sign extended, counted in words
	wire [15:0] offset_ext = {{(16 - exec_pkg::OFFSET_W){req.offset[exec_pkg::OFFSET_W-1]}}, req.offset};
	wire [15:0] pc_plus1   = req.pc + exec_pkg::PC_STEP;
	wire [15:0] pc_branch  = req.pc + offset_ext + exec_pkg::PC_STEP;
	wire [15:0] pc_skip    = req.pc + (req.next_two_word ? exec_pkg::PC_SKIP_LONG : exec_pkg::PC_SKIP_SHORT);

	// ----------------------------------------
	// Result, flags and clock count at take
	// ----------------------------------------
	always_comb begin
		res_take           = '0;
		res_take.pc_next   = pc_plus1;
		res_take.push_addr = pc_plus1;
		status_register_take          = status_register_reg;
		cyc_take           = exec_pkg::CYC_ALU;
		if (is_arith) begin
			res_take.dst_we               = !is_cmp;
			res_take.dst_data             = add_r;
			status_register_take[exec_pkg::FLAG_Z]   = add_z;
			status_register_take[exec_pkg::FLAG_C]   = add_c;
			status_register_take[exec_pkg::FLAG_N]   = add_r[7];
			status_register_take[exec_pkg::FLAG_V]   = add_v;
			status_register_take[exec_pkg::FLAG_H]   = add_h;
		end
		if (is_logic) begin
			res_take.dst_we               = (op != exec_pkg::OP_TEST);
			res_take.dst_data             = logic_res;
			status_register_take[exec_pkg::FLAG_Z]   = (logic_res == 8'h00);
			status_register_take[exec_pkg::FLAG_N]   = logic_res[7];
			status_register_take[exec_pkg::FLAG_V]   = 1'b0;
		end
		if (is_word) begin
			cyc_take = exec_pkg::CYC_WORD;
		end
		if (op == exec_pkg::OP_JUMP_PTR) begin
			res_take.pc_next = req.ptr;
			cyc_take         = exec_pkg::CYC_JUMP;
		end
		if (op == exec_pkg::OP_CALL_PTR) begin
			res_take.pc_next = req.ptr;
			res_take.push_en = 1'b1;
			cyc_take         = exec_pkg::CYC_CALL;
		end
		if (is_skip) begin
			res_take.pc_next = skip_cond ? pc_skip : pc_plus1;
			cyc_take         = !skip_cond ? exec_pkg::CYC_NO_SKIP :
			                   (req.next_two_word ? exec_pkg::CYC_SKIP_LONG : exec_pkg::CYC_SKIP_SHORT);
		end
		if (is_branch) begin
			res_take.pc_next = br_taken ? pc_branch : pc_plus1;
			cyc_take         = br_taken ? exec_pkg::CYC_BR_TAKEN : exec_pkg::CYC_BR_NOT;
		end
	end

	// ----------------------------------------
	// Word completion in the second clock
	// ----------------------------------------
	always_comb begin
		res_fin   = pend_reg;
		status_register_word = status_register_pend_reg;
		if (word_op_reg) begin
			res_fin.word_we              = 1'b1;
			res_fin.word_data            = {add_r, lo_res_reg};
			status_register_word[exec_pkg::FLAG_Z]  = add_z & lo_zero_reg;
			status_register_word[exec_pkg::FLAG_C]  = add_c;
			status_register_word[exec_pkg::FLAG_N]  = add_r[7];
			status_register_word[exec_pkg::FLAG_V]  = add_v;
			status_register_word[exec_pkg::FLAG_S]  = add_r[7] ^ add_v;
		end
	end

	// ----------------------------------------
	// Sequencer: take, count clocks, finish
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			cnt_reg       <= '0;
			done_reg      <= 1'b0;
			res_reg       <= '0;
			pend_reg      <= '0;
			status_register_reg      <= exec_pkg::STATUS_RESET;
			status_register_pend_reg <= exec_pkg::STATUS_RESET;
			word_op_reg   <= 1'b0;
			word_sub_reg  <= 1'b0;
			word_hi_reg   <= 8'h00;
			carry_reg     <= 1'b0;
			lo_res_reg    <= 8'h00;
			lo_zero_reg   <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						word_op_reg   <= is_word;
						word_sub_reg  <= is_sub;
						word_hi_reg   <= req.word[15:8];
						carry_reg     <= add_c;
						lo_res_reg    <= add_r;
						lo_zero_reg   <= add_z;
						pend_reg      <= res_take;
						status_register_pend_reg <= status_register_take;
						if (cyc_take == exec_pkg::CYC_ALU) begin
							res_reg  <= res_take;
							status_register_reg <= status_register_take;
							done_reg <= 1'b1;
						end else begin
							state_reg <= ST_BUSY;
							cnt_reg   <= cyc_take - 2'h1;
						end
					end
				end
				ST_BUSY: begin
					cnt_reg <= cnt_reg - 2'h1;
					if (cnt_reg == 2'h1) begin
						state_reg <= ST_IDLE;
						res_reg   <= res_fin;
						status_register_reg  <= status_register_word;
						done_reg  <= 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign ready           = (state_reg == ST_IDLE);
	assign done            = done_reg;
	assign res             = res_reg;
	assign status_register = status_register_reg;

endmodule

//--- sim/exec_unit_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checks of the execution unit
// ----------------------------------------
module exec_unit_monitor (
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                start,
	input wire exec_pkg::exec_req_t req,
	input wire logic                ready,
	input wire logic                done,
	input wire exec_pkg::exec_res_t res,
	input wire logic [7:0]          status_register
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Request accepted on this edge
	wire take = start && ready;

	property p_add;
		take && req.op == exec_pkg::OP_ADD |=> done && res.dst_we && res.dst_data == $past(req.dst) + $past(req.src);
	endproperty
	a_add: assert property (p_add) else $error("add result or latency");
	property p_word;
		take && (req.op == exec_pkg::OP_ADD_IMM_WORD || req.op == exec_pkg::OP_SUB_IMM_WORD)
			|=> !done && !ready ##1 done && res.word_we;
	endproperty
	a_word: assert property (p_word) else $error("word op latency");
	property p_sub;
		take && req.op == exec_pkg::OP_SUB |=> res.dst_data == $past(req.dst) - $past(req.src)
			&& status_register[exec_pkg::FLAG_C] == ($past(req.dst) < $past(req.src));
	endproperty
	a_sub: assert property (p_sub) else $error("subtract result or borrow");
	property p_xor;
		take && req.op == exec_pkg::OP_XOR |=> res.dst_data == ($past(req.dst) ^ $past(req.src))
			&& !status_register[exec_pkg::FLAG_V];
	endproperty
	a_xor: assert property (p_xor) else $error("exclusive or result");
	property p_test;
		take && req.op == exec_pkg::OP_TEST |=> done && !res.dst_we
			&& status_register[exec_pkg::FLAG_Z] == ($past(req.dst) == 8'h00);
	endproperty
	a_test: assert property (p_test) else $error("test wrote or bad zero");
	property p_jump;
		take && req.op == exec_pkg::OP_JUMP_PTR |=> !done ##1 done && res.pc_next == $past(req.ptr, 2);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target or latency");
	property p_call;
		take && req.op == exec_pkg::OP_CALL_PTR |=> !done [*2] ##1 done && res.push_en
			&& res.push_addr == $past(req.pc, 3) + 16'h0001;
	endproperty
	a_call: assert property (p_call) else $error("call push or latency");
	property p_cmp;
		take && req.op inside {exec_pkg::OP_CMP, exec_pkg::OP_CMP_IMM} |=> done && !res.dst_we
			&& status_register[exec_pkg::FLAG_Z] == ($past(req.dst) == $past(req.src));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare stored or bad zero");
	property p_keep;
		take && req.op inside {exec_pkg::OP_CMP_SKIP_EQ, exec_pkg::OP_SKIP_REG_SET, exec_pkg::OP_SKIP_REG_CLEAR,
			exec_pkg::OP_SKIP_IO_SET, exec_pkg::OP_SKIP_IO_CLEAR} |=> $stable(status_register);
	endproperty
	a_keep: assert property (p_keep) else $error("skip changed flags");
	property p_br;
		take && req.op == exec_pkg::OP_BR_FLAG_SET && status_register[req.bit_sel] |=> !done ##1 done
			&& res.pc_next == $past(req.pc, 2) + {{9{$past(req.offset[6], 2)}}, $past(req.offset, 2)} + 16'h0001;
	endproperty
	a_br: assert property (p_br) else $error("taken branch target");
endmodule

//--- sim/fetch_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Program counter of the fetch side
// ----------------------------------------
module fetch_model #(
	parameter logic [15:0] PC_START = 16'h0100
) (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                done,
	input  wire exec_pkg::exec_res_t res,
	output logic [15:0]              pc
);
	// Follow the unit's next address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pc <= PC_START;
		end else if (done) begin
			pc <= res.pc_next;
		end
	end
endmodule

//--- sim/mcu_arith_logic_branch_unit_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ----------------------------------------
// Bench of the execution unit
// ----------------------------------------
module mcu_arith_logic_branch_unit_tb;
	logic                sys_clk;
	logic                rst;
	logic                start;
	logic                ready;
	logic                done;
	exec_pkg::exec_req_t req;
	exec_pkg::exec_req_t r;
	exec_pkg::exec_res_t res;
	logic [7:0]          status_register;
	logic [7:0]          sp;
	logic [15:0]         pc_now;
	logic [15:0]         p;
	int                  fail_count = 0;
	int                  comparisons = 0;
	int                  n;
	int                  cyc = 0;

	exec_unit DUT (.sys_clk(sys_clk), .rst(rst), .start(start), .req(req), .ready(ready), .done(done),
		.res(res), .status_register(status_register));
	fetch_model u_fetch (.sys_clk(sys_clk), .rst(rst), .done(done), .res(res), .pc(pc_now));

	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			close_out;
		end
	end

	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// One request, counting cycles to done
	task go(input exec_pkg::op_t op, input logic [7:0] d, input logic [7:0] s);
		// Let an edge pass so start never falls and rises in one step
		@(posedge sys_clk);
		#1;
		r.op = op;
		r.dst = d;
		r.src = s;
		r.pc = pc_now;
		p = pc_now;
		sp = status_register;
		req = r;
		start = 1'b1;
		@(posedge sys_clk);
		#1;
		start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask
	task alu(input logic [7:0] e, input logic [7:0] st);
		`CHK("result", e, res.dst_data)
		`CHK("write", 1'b1, res.dst_we)
		`CHK("status", st, status_register)
		`CHK("cycles", 1, n)
	endtask
	task flow(input logic [15:0] e, input int en);
		`CHK("pc_next", e, res.pc_next)
		`CHK("cycles", en, n)
		`CHK("status", sp, status_register)
	endtask

	task t_add;
		go(exec_pkg::OP_ADD, 8'h0F, 8'h01); alu(8'h10, 8'h20);
		go(exec_pkg::OP_ADD, 8'hFF, 8'h01); alu(8'h00, 8'h23);
		go(exec_pkg::OP_ADD_CARRY, 8'h01, 8'h01); alu(8'h03, 8'h00);
	endtask
	task t_sub;
		go(exec_pkg::OP_SUB, 8'h10, 8'h20); alu(8'hF0, 8'h05);
		go(exec_pkg::OP_SUB_BORROW, 8'h05, 8'h01); alu(8'h03, 8'h00);
		go(exec_pkg::OP_SUB_CONST, 8'h00, 8'h01); alu(8'hFF, 8'h25);
		go(exec_pkg::OP_SUB_CONST_BORROW, 8'h10, 8'h0F); alu(8'h00, 8'h22);
	endtask
	task t_word;
		r.word = 16'h00FF;
		go(exec_pkg::OP_ADD_IMM_WORD, 8'h00, 8'h01);
		`CHK("word", 16'h0100, res.word_data)
		`CHK("status", 8'h20, status_register)
		`CHK("cycles", 2, n)
		r.word = 16'h0000;
		go(exec_pkg::OP_SUB_IMM_WORD, 8'h00, 8'h01);
		`CHK("word", 16'hFFFF, res.word_data)
		`CHK("status", 8'h35, status_register)
		`CHK("cycles", 2, n)
	endtask
	task t_logic;
		exec_pkg::op_t ops [7] = '{exec_pkg::OP_AND, exec_pkg::OP_AND_CONST, exec_pkg::OP_OR, exec_pkg::OP_OR_CONST,
			exec_pkg::OP_XOR, exec_pkg::OP_SET_BITS, exec_pkg::OP_CLEAR_BITS};
		logic [7:0] ex [7] = '{8'h30, 8'h30, 8'hFC, 8'hFC, 8'hCC, 8'hFC, 8'hC0};
		for (int i = 0; i < 7; i++) begin
			go(ops[i], 8'hF0, 8'h3C); alu(ex[i], 8'h31 | (ex[i][7] ? 8'h04 : 8'h00));
		end
		go(exec_pkg::OP_TEST, 8'h00, 8'h00);
		`CHK("write", 1'b0, res.dst_we)
		`CHK("status", 8'h33, status_register)
	endtask
	task t_cmp;
		go(exec_pkg::OP_CMP, 8'h05, 8'h05);
		`CHK("write", 1'b0, res.dst_we)
		`CHK("status", 8'h12, status_register)
		go(exec_pkg::OP_CMP_IMM, 8'h00, 8'h01);
		`CHK("status", 8'h35, status_register)
		go(exec_pkg::OP_CMP_BORROW, 8'h01, 8'h00);
		`CHK("status", 8'h12, status_register)
	endtask
	task t_branch;
		r.bit_sel = 3'h1;
		r.offset = 7'h7E;
		go(exec_pkg::OP_BR_FLAG_SET, 8'h00, 8'h00); flow(p - 16'h0001, 2);
		go(exec_pkg::OP_BR_FLAG_CLEAR, 8'h00, 8'h00); flow(p + 16'h0001, 1);
		r.bit_sel = 3'h0;
		r.offset = 7'h3F;
		go(exec_pkg::OP_BR_FLAG_CLEAR, 8'h00, 8'h00); flow(p + 16'h0040, 2);
	endtask
	task t_flow;
		r.ptr = 16'h1234;
		go(exec_pkg::OP_JUMP_PTR, 8'h00, 8'h00); flow(16'h1234, 2);
		r.ptr = 16'h0456;
		go(exec_pkg::OP_CALL_PTR, 8'h00, 8'h00); flow(16'h0456, 3);
		`CHK("push_addr", p + 16'h0001, res.push_addr)
	endtask
	task t_skip;
		r.next_two_word = 1'b1;
		go(exec_pkg::OP_CMP_SKIP_EQ, 8'h5A, 8'h5A); flow(p + 16'h0003, 3);
		go(exec_pkg::OP_CMP_SKIP_EQ, 8'h5A, 8'h5B); flow(p + 16'h0001, 1);
		r.next_two_word = 1'b0;
		r.bit_sel = 3'h3;
		go(exec_pkg::OP_SKIP_REG_SET, 8'h08, 8'h08); flow(p + 16'h0002, 2);
		go(exec_pkg::OP_SKIP_REG_CLEAR, 8'h08, 8'h08); flow(p + 16'h0001, 1);
		r.io_val = 8'h08;
		r.bit_sel = 3'h2;
		go(exec_pkg::OP_SKIP_IO_CLEAR, 8'h00, 8'h00); flow(p + 16'h0002, 2);
		go(exec_pkg::OP_SKIP_IO_SET, 8'h00, 8'h00); flow(p + 16'h0001, 1);
	endtask

	// Reset, then scenarios back to back
	initial begin
		rst = 1'b1;
		start = 1'b0;
		r = '0;
		req = '0;
		repeat (20) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_add;
		t_sub;
		t_word;
		t_logic;
		t_cmp;
		t_branch;
		t_flow;
		t_skip;
		close_out;
	end
endmodule

bind exec_unit exec_unit_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .start(start), .req(req), .ready(ready),
	.done(done), .res(res), .status_register(status_register));
